/* File: rtl/ldr_pkg.sv */
// constants, states and helpers for the read-burst core of a dual-channel low-power dram die
// assumes a 20 MHz system clock that oversamples the command clock coming from the controller
package ldr_pkg;
   localparam int LDR_DQ_W = 8;
   localparam int LDR_CA_W = 6;
   localparam int LDR_RL_W = 6;
   localparam int LDR_RL_MAX = 32;
   localparam int LDR_COL_W = 8;
   localparam int LDR_FIFO_DEPTH = 32;
   localparam int LDR_TS_W = 16;
   localparam int LDR_HIST = 4;

   // command encodings seen on the six command lines at a command-clock rise
   localparam logic [4:0] LDR_OP_READ1 = 5'h02;
   localparam logic [4:0] LDR_OP_CAS2 = 5'h12;
   localparam int LDR_OP_MSB = 4;
   localparam int LDR_BL_BIT = 5;
   localparam int LDR_ACT_BIT0 = 0;
   localparam int LDR_ACT_BIT1 = 1;
   localparam logic [1:0] LDR_COL_LOW = 2'h0;

   // strobe framing, counted in half command-clock periods
   localparam int LDR_PRE_HALVES = 4;
   localparam int LDR_PRE_TOGGLE_HALF = 1;
   localparam int LDR_POST_STD_HALVES = 1;
   localparam int LDR_POST_EXT_HALVES = 3;
   localparam int LDR_BL16 = 16;
   localparam int LDR_BL32 = 32;

   // activate spacing limits
   localparam int LDR_RRD_PS = 10000;
   localparam int LDR_RRD_TOP_PS = 7500;
   localparam int LDR_FAW_PS = 40000;
   localparam int LDR_FAW_TOP_PS = 30000;
   localparam int LDR_RRD_NCK = 4;
   localparam int LDR_FAW_NCK = 1;

   typedef enum logic [1:0]
   {
      LDR_IDLE = 2'b00,
      LDR_PRE = 2'b01,
      LDR_DATA = 2'b10,
      LDR_POST = 2'b11
   } ldr_burst_t;

   // least time in clocks: rounds up, never below the clock floor
   function automatic int ldr_cycles(input int ps, input int tck_ps, input int nck);
      int c;
      c = (ps + tck_ps - 1) / tck_ps;
      return (c > nck) ? c : nck;
   endfunction
endpackage

/* File: rtl/ldr_fifo.sv */
// read-data buffer between the array and the strobe sequencer
// assumes one clock domain; depth is a power of two
`timescale 1ns/1ps
module ldr_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 32
)(
   input wire logic clk_i,          // system clock
   input wire logic rst_i,          // async reset, high
   input wire logic [W-1:0] in_data_i, // word from array
   input wire logic in_valid_i,     // word offered
   output logic in_ready_o,         // room left
   output logic [W-1:0] out_data_o, // registered head word
   output logic out_valid_o,        // head word valid
   input wire logic out_ready_i     // head word taken
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [AW:0] cnt;
      logic in_ready;
      logic out_valid;
      logic [W-1:0] out_data;
   } ldr_fifo_st_t;

   ldr_fifo_st_t q, d;
   logic wr;
   logic ld;

   always_comb
   begin
      d = q;
      wr = in_valid_i & q.in_ready;
      ld = (~q.out_valid | out_ready_i) & (q.cnt != '0);
      if (wr)
      begin
         d.mem[q.wptr] = in_data_i;
         d.wptr = q.wptr + AW'(1);
      end
      // output stage is a register, so the head word never comes from the array directly
      if (ld)
      begin
         d.out_data = q.mem[q.rptr];
         d.out_valid = 1'b1;
         d.rptr = q.rptr + AW'(1);
      end
      else if (out_ready_i)
      begin
         d.out_valid = 1'b0;
      end
      d.cnt = q.cnt + (AW+1)'(wr) - (AW+1)'(ld);
      d.in_ready = d.cnt < (AW+1)'(DEPTH);
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         q <= '0;
      else
         q <= d;
   end

   assign in_ready_o = q.in_ready;
   assign out_data_o = q.out_data;
   assign out_valid_o = q.out_valid;
endmodule

/* File: rtl/ldr_read_core.sv */
// read command decode, latency scheduling and strobe/data framing of one channel
// assumes the command clock, select, enable and command lines arrive from another domain
// and are oversampled here; both command-clock edges act as half-clock ticks
`timescale 1ns/1ps
module ldr_read_core #(
   parameter int DQ_W = ldr_pkg::LDR_DQ_W,
   parameter int RL_MAX = ldr_pkg::LDR_RL_MAX,
   parameter int FIFO_DEPTH = ldr_pkg::LDR_FIFO_DEPTH,
   parameter int LINK_TCK_PS = 400000,
   parameter bit RATED_TOP = 1'b1
)(
   input wire logic clk_i,                                  // system clock
   input wire logic rst_i,                                  // async reset, high
   input wire logic ck_i,                                   // command clock pin
   input wire logic cke_i,                                  // clock enable pin
   input wire logic cs_i,                                   // chip select pin
   input wire logic [ldr_pkg::LDR_CA_W-1:0] ca_i,           // command lines
   input wire logic [ldr_pkg::LDR_RL_W-1:0] read_latency_i, // programmed latency, clocks
   input wire logic toggle_preamble_i,                      // 1: toggling preamble
   input wire logic ext_postamble_i,                        // 1: 1.5-clock postamble
   input wire logic burst_otf_i,                            // 1: length from command
   input wire logic bl32_default_i,                         // fixed length select
   input wire logic [DQ_W-1:0] rd_data_i,                   // beat from array
   input wire logic rd_valid_i,                             // beat offered
   output logic rd_ready_o,                                 // buffer has room
   output logic rd_req_o,                                   // burst fetch request
   output logic [ldr_pkg::LDR_COL_W-1:0] rd_col_o,          // burst start column
   output logic rd_bl32_o,                                  // request is 32 beats
   output logic [DQ_W-1:0] dq_o,                            // data out
   output logic dq_oe_o,                                    // data driven
   output logic dqs_o,                                      // strobe out
   output logic dqs_oe_o,                                   // strobe driven
   output logic underrun_o,                                 // beat sent without data
   output logic act_timing_err_o                            // activate spacing broken
);
   import ldr_pkg::*;

   localparam int SCHED_W = 2 * RL_MAX;
   localparam int RRD_CYC = ldr_cycles(RATED_TOP ? LDR_RRD_TOP_PS : LDR_RRD_PS, LINK_TCK_PS, LDR_RRD_NCK);
   localparam int FAW_CYC = ldr_cycles(RATED_TOP ? LDR_FAW_TOP_PS : LDR_FAW_PS, LINK_TCK_PS, LDR_FAW_NCK);

   typedef struct packed {
      logic ck_s1;
      logic ck_s2;
      logic ck_p;
      logic cke_s1;
      logic cke_s2;
      logic cs_s1;
      logic cs_s2;
      logic [LDR_CA_W-1:0] ca_s1;
      logic [LDR_CA_W-1:0] ca_s2;
      logic rd1_seen;
      logic rd1_bl32;
      logic [SCHED_W-1:0] sched;
      logic [SCHED_W-1:0] sched_bl;
      ldr_burst_t st;
      logic [5:0] cnt;
      logic req;
      logic [LDR_COL_W-1:0] col;
      logic bl32;
      logic [DQ_W-1:0] dq;
      logic dq_oe;
      logic dqs;
      logic dqs_oe;
      logic underrun;
      logic [LDR_TS_W-1:0] cyc;
      logic [LDR_HIST-1:0][LDR_TS_W-1:0] act_ts;
      logic [2:0] act_n;
      logic act_err;
   } ldr_core_st_t;

   ldr_core_st_t q, d;
   logic [DQ_W-1:0] head_data;
   logic head_valid;
   logic pop;

   ldr_fifo #(
      .W(DQ_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_data_i(rd_data_i),
      .in_valid_i(rd_valid_i),
      .in_ready_o(rd_ready_o),
      .out_data_o(head_data),
      .out_valid_o(head_valid),
      .out_ready_i(pop)
   );

   // length of a burst in beats, less one, for the down-counter
   function automatic logic [5:0] beats_left(input logic bl32);
      return bl32 ? 6'(LDR_BL32 - 1) : 6'(LDR_BL16 - 1);
   endfunction

   always_comb
   begin
      logic rise;
      logic edge_any;
      logic start_now;
      logic start_bl32;
      logic pre_now;
      logic cmd_ok;
      logic cas2;
      logic act1;
      logic bl_sel;
      logic [6:0] ins;
      logic [LDR_TS_W-1:0] age;
      rise = 1'b0;
      edge_any = 1'b0;
      start_now = 1'b0;
      start_bl32 = 1'b0;
      pre_now = 1'b0;
      cmd_ok = 1'b0;
      cas2 = 1'b0;
      act1 = 1'b0;
      bl_sel = 1'b0;
      ins = '0;
      age = '0;
      pop = 1'b0;
      d = q;
      d.ck_s1 = ck_i;
      d.ck_s2 = q.ck_s1;
      d.ck_p = q.ck_s2;
      d.cke_s1 = cke_i;
      d.cke_s2 = q.cke_s1;
      d.cs_s1 = cs_i;
      d.cs_s2 = q.cs_s1;
      d.ca_s1 = ca_i;
      d.ca_s2 = q.ca_s1;
      d.req = 1'b0;
      d.underrun = 1'b0;
      d.act_err = 1'b0;

      rise = q.ck_s2 & ~q.ck_p;
      edge_any = q.ck_s2 ^ q.ck_p;
      cmd_ok = rise & q.cs_s2 & q.cke_s2;

      // latency schedule advances one slot per half clock
      if (edge_any)
      begin
         start_now = q.sched[0];
         start_bl32 = q.sched_bl[0];
         pre_now = q.sched[LDR_PRE_HALVES];
         d.sched = q.sched >> 1;
         d.sched_bl = q.sched_bl >> 1;
      end

      if (rise)
         d.cyc = q.cyc + LDR_TS_W'(1);

      if (cmd_ok)
      begin
         if (q.ca_s2[LDR_OP_MSB:0] == LDR_OP_READ1)
         begin
            d.rd1_seen = 1'b1;
            d.rd1_bl32 = q.ca_s2[LDR_BL_BIT];
         end
         else if (q.rd1_seen)
         begin
            cas2 = 1'b1;
            d.rd1_seen = 1'b0;
         end
         act1 = q.ca_s2[LDR_ACT_BIT0] & ~q.ca_s2[LDR_ACT_BIT1];
      end

      if (cas2)
      begin
         bl_sel = burst_otf_i ? q.rd1_bl32 : bl32_default_i;
         // data begins read_latency clocks after this second rise
         ins = 7'({read_latency_i, 1'b0}) - 7'd1;
         if (ins < 7'(SCHED_W))
         begin
            d.sched[ins[5:0]] = 1'b1;
            d.sched_bl[ins[5:0]] = bl_sel;
         end
         d.req = 1'b1;
         d.col = {q.ca_s2, LDR_COL_LOW};
         d.bl32 = bl_sel;
      end

      // activate spacing check against the rated limits
      if (act1)
      begin
         age = q.cyc - q.act_ts[0];
         if (q.act_n != '0 && age < LDR_TS_W'(RRD_CYC))
            d.act_err = 1'b1;
         age = q.cyc - q.act_ts[LDR_HIST-1];
         if (q.act_n == 3'(LDR_HIST) && age < LDR_TS_W'(FAW_CYC))
            d.act_err = 1'b1;
         d.act_ts = {q.act_ts[LDR_HIST-2:0], q.cyc};
         if (q.act_n != 3'(LDR_HIST))
            d.act_n = q.act_n + 3'd1;
      end

      if (edge_any)
      begin
         case (q.st)
            LDR_IDLE:
            begin
               if (pre_now)
               begin
                  d.st = LDR_PRE;
                  d.cnt = '0;
                  d.dqs = 1'b0;
                  d.dqs_oe = 1'b1;
               end
            end
            LDR_PRE:
            begin
               d.cnt = q.cnt + 6'd1;
               d.dqs = toggle_preamble_i & (q.cnt == 6'(LDR_PRE_TOGGLE_HALF));
            end
            LDR_DATA:
            begin
               if (q.cnt != '0)
               begin
                  d.cnt = q.cnt - 6'd1;
                  d.dqs = ~q.dqs;
                  d.dq = head_data;
                  pop = 1'b1;
               end
               else if (!start_now)
               begin
                  d.st = LDR_POST;
                  d.cnt = ext_postamble_i ? 6'(LDR_POST_EXT_HALVES - 1) : 6'(LDR_POST_STD_HALVES - 1);
                  d.dqs = 1'b0;
                  d.dq_oe = 1'b0;
               end
            end
            LDR_POST:
            begin
               if (pre_now)
               begin
                  d.st = LDR_PRE;
                  d.cnt = '0;
                  d.dqs = 1'b0;
               end
               else if (q.cnt == '0)
               begin
                  d.st = LDR_IDLE;
                  d.dqs_oe = 1'b0;
               end
               else
               begin
                  d.cnt = q.cnt - 6'd1;
               end
            end
            default:
            begin
               d.st = LDR_IDLE;
            end
         endcase

         // a new burst landing on the last beat runs on without a preamble
         if (start_now && (q.st == LDR_PRE || q.st == LDR_POST || (q.st == LDR_DATA && q.cnt == '0)))
         begin
            d.st = LDR_DATA;
            d.cnt = beats_left(start_bl32);
            d.dqs = 1'b1;
            d.dqs_oe = 1'b1;
            d.dq = head_data;
            d.dq_oe = 1'b1;
            pop = 1'b1;
         end
      end

      // the array missed its deadline; the beat goes out with stale data
      if (pop && !head_valid)
         d.underrun = 1'b1;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         q <= '0;
      else
         q <= d;
   end

   assign rd_req_o = q.req;
   assign rd_col_o = q.col;
   assign rd_bl32_o = q.bl32;
   assign dq_o = q.dq;
   assign dq_oe_o = q.dq_oe;
   assign dqs_o = q.dqs;
   assign dqs_oe_o = q.dqs_oe;
   assign underrun_o = q.underrun;
   assign act_timing_err_o = q.act_err;
endmodule

/* File: bench/ldr_read_core_assertions.sv */
// checker for strobe and data framing of the read core
// assumes 8 system clocks per command clock; bound from the bench
`timescale 1ns/1ps
module ldr_read_core_assertions (
   input wire logic clk_i, // clock
   input wire logic rst_i, // reset
   input wire logic toggle_preamble_i, // mode
   input wire logic ext_postamble_i, // mode
   input wire logic rd_req_o, // fetch
   input wire logic [ldr_pkg::LDR_COL_W-1:0] rd_col_o, // column
   input wire logic dq_oe_o, // data on
   input wire logic dqs_o, // strobe
   input wire logic dqs_oe_o // strobe on
);
   import ldr_pkg::*;
   logic [6:0] beat_q;
   logic dqs_q;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // beats of the current data run, one per strobe change
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         beat_q <= 7'h00;
         dqs_q <= 1'b0;
      end
      else
      begin
         beat_q <= dq_oe_o ? beat_q + 7'(dqs_o != dqs_q) : 7'h00;
         dqs_q <= dqs_o;
      end
   end
   AST_COL_LOW: assert property (rd_req_o |-> rd_col_o[1:0] == LDR_COL_LOW)
      else $error("start column not a multiple of four");
   AST_REQ_PULSE: assert property (rd_req_o |=> !rd_req_o)
      else $error("fetch request longer than one cycle");
   AST_DQ_IN_STROBE: assert property (dq_oe_o |-> dqs_oe_o)
      else $error("data driven without strobe");
   AST_FIRST_RISE: assert property ($rose(dq_oe_o) |-> dqs_o)
      else $error("first beat not on a rising strobe");
   AST_PRE_LEN: assert property ($rose(dqs_oe_o) |-> !dq_oe_o [*8] ##1 !dq_oe_o [*8] ##1 dq_oe_o)
      else $error("preamble not two command clocks");
   AST_PRE_STATIC: assert property (dqs_oe_o && !dq_oe_o && !toggle_preamble_i |-> !dqs_o)
      else $error("strobe high outside data with static preamble");
   AST_POST_STD: assert property ($fell(dq_oe_o) && !ext_postamble_i |-> dqs_oe_o [*4] ##1 !dqs_oe_o)
      else $error("standard postamble not half a clock");
   AST_POST_EXT: assert property ($fell(dq_oe_o) && ext_postamble_i |-> dqs_oe_o [*8] ##1 dqs_oe_o [*4] ##1 !dqs_oe_o)
      else $error("extended postamble not 1.5 clocks");
   AST_BEAT_HOLD: assert property (dq_oe_o && $changed(dqs_o) |=> $stable(dqs_o) [*3])
      else $error("strobe edge spacing wrong");
   AST_BURST_LEN: assert property ($fell(dq_oe_o) |-> beat_q != 7'h00 && beat_q[3:0] == 4'h0)
      else $error("data run not whole bursts");
   cover property (rd_req_o);
   cover property ($fell(dq_oe_o) && ext_postamble_i);
   cover property (dq_oe_o && beat_q == 7'h21);
endmodule

/* File: bench/ldr_ctrl_model.sv */
// controller and array model facing the read core
// assumes cmd and gap are called in order from one bench process
`timescale 1ns/1ps
module ldr_ctrl_model (
   input wire logic clk_i, // system clock
   input wire logic rd_req_i, // fetch
   input wire logic [7:0] rd_col_i, // start column
   input wire logic rd_bl32_i, // 32 beats
   input wire logic rd_ready_i, // room
   output logic ck_o, // command clock
   output logic cke_o, // clock enable
   output logic cs_o, // select
   output logic [5:0] ca_o, // command lines
   output logic [7:0] rd_data_o, // beat
   output logic rd_valid_o // beat offered
);
   logic [7:0] q[$];
   logic slow;
   logic took;
   initial
   begin
      {cke_o, cs_o, ca_o, rd_data_o, rd_valid_o, slow, took} = '0;
      ck_o = 1'b0;
      #37;
      forever #200 ck_o = ~ck_o; // runs free, odd phase to the system clock
   end
   // only reads and activates are sent, so no precharge, refresh, power-down or write spacing falls due
   task automatic cmd(input logic s, input logic e, input logic [5:0] c);
      @(negedge ck_o);
      cs_o = s;
      cke_o = e;
      ca_o = c;
      @(posedge ck_o);
   endtask
   task automatic gap(input int n);
      repeat (n)
      begin
         @(negedge ck_o);
         cs_o = 1'b0;
         ca_o = ~ca_o; // deselected lines never hold a stale value
      end
   endtask
   // slow mode drops valid after each take to stall the buffer
   always @(posedge clk_i)
   begin
      took = rd_valid_o && rd_ready_i;
      if (took)
         void'(q.pop_front());
      if (rd_req_i)
         for (int i = 0; i < (rd_bl32_i ? 32 : 16); i++)
            q.push_back(rd_col_i + 8'(i));
      #1;
      rd_valid_o = q.size() > 0 && !(slow && took);
      rd_data_o = rd_valid_o ? q[0] : ~rd_data_o;
   end
endmodule

/* File: bench/ldr_read_core_tb.sv */
// self-checking bench for the read core
// assumes a 50 ns system clock and the free 400 ns command clock of the model
`timescale 1ns/1ps
module ldr_read_core_tb;
   import ldr_pkg::*;
   logic clk_i, rst_i, ck, cke, cs, tog, ext, otf, b32d, rv, rr, req, b32, dqoe, dqs, dqsoe, und, aerr;
   logic [5:0] ca, rl;
   logic [7:0] rd, col, dq, cap_col;
   logic cap_b32, dqoe_q, dqsoe_q, dqs_q;
   int fails, n_tests, cyc, t_req, t_dq, t_pre, t_off, t_end, n_req, n_dqon, n_pre, pre_hi, n_und, n_err, full;
   logic [7:0] got[$];
   ldr_read_core uut (.clk_i(clk_i), .rst_i(rst_i), .ck_i(ck), .cke_i(cke), .cs_i(cs), .ca_i(ca),
      .read_latency_i(rl), .toggle_preamble_i(tog), .ext_postamble_i(ext), .burst_otf_i(otf),
      .bl32_default_i(b32d), .rd_data_i(rd), .rd_valid_i(rv), .rd_ready_o(rr), .rd_req_o(req), .rd_col_o(col),
      .rd_bl32_o(b32), .dq_o(dq), .dq_oe_o(dqoe), .dqs_o(dqs), .dqs_oe_o(dqsoe), .underrun_o(und),
      .act_timing_err_o(aerr));
   ldr_ctrl_model m (.clk_i(clk_i), .rd_req_i(req), .rd_col_i(col), .rd_bl32_i(b32), .rd_ready_i(rr),
      .ck_o(ck), .cke_o(cke), .cs_o(cs), .ca_o(ca), .rd_data_o(rd), .rd_valid_o(rv));
   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   always @(negedge clk_i)
   begin
      cyc++;
      if (req === 1'b1)
      begin
         n_req++;
         t_req = cyc;
         cap_col = col;
         cap_b32 = b32;
      end
      if (dqoe && !dqoe_q)
      begin
         n_dqon++;
         t_dq = cyc;
      end
      if (dqsoe && !dqsoe_q)
      begin
         n_pre++;
         t_pre = cyc;
      end
      if (!dqoe && dqoe_q)
         t_off = cyc;
      if (!dqsoe && dqsoe_q)
         t_end = cyc;
      if (dqoe && dqs !== dqs_q)
         got.push_back(dq);
      if (dqsoe && !dqoe && dqs)
         pre_hi++;
      n_und += int'(und);
      n_err += int'(aerr);
      full |= int'(!rr && !rst_i);
      {dqoe_q, dqsoe_q, dqs_q} = {dqoe, dqsoe, dqs};
   end
   task automatic clr;
      got.delete();
      {n_req, n_dqon, n_pre, pre_hi, n_und, n_err, full} = '0;
   endtask
   task automatic check_eq(input string what, input logic [31:0] exp, input logic [31:0] seen);
      n_tests++;
      if (exp !== seen)
      begin
         fails++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic cfg(input logic [5:0] l, input logic t, input logic x, input logic o, input logic b);
      @(posedge clk_i);
      #1;
      {rl, tog, ext, otf, b32d} = {l, t, x, o, b};
      clr();
   endtask
   task automatic one_read(input logic [5:0] l, input logic t, x, o, b, bl, input logic [5:0] c);
      int nb;
      nb = (o ? bl : b) ? 32 : 16;
      cfg(l, t, x, o, b);
      m.cmd(1'b1, 1'b1, {bl, LDR_OP_READ1});
      m.cmd(1'b1, 1'b1, c);
      m.gap(int'(l) + 40);
      check_eq("req_count", 1, n_req);
      check_eq("start_col", {c, 2'b00}, cap_col);
      check_eq("bl32", nb == 32, cap_b32);
      check_eq("latency", 8 * l, t_dq - t_req);
      check_eq("preamble", 16, t_dq - t_pre);
      check_eq("pre_high", t ? 4 : 0, pre_hi);
      check_eq("postamble", x ? 12 : 4, t_end - t_off);
      check_eq("beats", nb, got.size());
      for (int i = 0; i < nb; i++)
         check_eq("beat", {c, 2'b00} + 8'(i), got[i]);
   endtask
   task automatic gapless;
      cfg(6'd32, 1'b0, 1'b0, 1'b0, 1'b1);
      m.slow = 1'b1;
      m.cmd(1'b1, 1'b1, {1'b0, LDR_OP_READ1});
      m.cmd(1'b1, 1'b1, 6'h10);
      m.gap(14);
      m.cmd(1'b1, 1'b1, {1'b0, LDR_OP_READ1});
      m.cmd(1'b1, 1'b1, 6'h14);
      m.gap(80);
      m.slow = 1'b0;
      check_eq("data_starts", 1, n_dqon);
      check_eq("preambles", 1, n_pre);
      check_eq("underruns", 0, n_und);
      check_eq("buffer_refused", 1, full);
      check_eq("beats", 64, got.size());
      for (int i = 0; i < 64; i++)
         check_eq("beat", (i < 32 ? 8'h40 : 8'h50) + 8'(i % 32), got[i]);
   endtask
   task automatic refusals;
      cfg(6'd8, 1'b0, 1'b0, 1'b0, 1'b0);
      m.cmd(1'b0, 1'b1, {1'b0, LDR_OP_READ1});
      m.cmd(1'b0, 1'b1, 6'h06);
      m.cmd(1'b1, 1'b0, {1'b0, LDR_OP_READ1});
      m.cmd(1'b1, 1'b0, 6'h06);
      m.cmd(1'b0, 1'b1, 6'h00);
      m.gap(5);
      m.cmd(1'b1, 1'b1, 6'h06);
      m.gap(30);
      check_eq("refused_reqs", 0, n_req);
      cfg(6'd40, 1'b0, 1'b0, 1'b0, 1'b0);
      m.cmd(1'b1, 1'b1, {1'b0, LDR_OP_READ1});
      m.cmd(1'b1, 1'b1, 6'h06);
      m.gap(60);
      check_eq("refused_bursts", 0, n_pre);
   endtask
   task automatic act_spacing;
      for (int s = 3; s < 5; s++)
      begin
         cfg(6'd8, 1'b0, 1'b0, 1'b0, 1'b0);
         m.cmd(1'b1, 1'b1, 6'h01);
         m.cmd(1'b1, 1'b1, 6'h03);
         m.gap(s - 2);
         m.cmd(1'b1, 1'b1, 6'h01);
         m.cmd(1'b1, 1'b1, 6'h03);
         m.gap(10);
         check_eq("act_spacing_err", s == 3, n_err);
      end
   endtask
   // reset lands mid-burst; the burst must die and a clean read must follow
   task automatic mid_reset;
      cfg(6'd8, 1'b1, 1'b0, 1'b0, 1'b0);
      m.cmd(1'b1, 1'b1, {1'b0, LDR_OP_READ1});
      m.cmd(1'b1, 1'b1, 6'h0c);
      m.gap(13);
      @(posedge clk_i);
      #1;
      check_eq("burst_running", 1, dqoe);
      rst_i = 1'b1;
      repeat (2) @(posedge clk_i);
      #1;
      rst_i = 1'b0;
      @(negedge clk_i);
      check_eq("reset_outputs", 0, {rr, req, dqoe, dqsoe, dqs, und, aerr, dq});
      @(negedge clk_i);
      check_eq("ready_after_reset", 1, rr);
      clr();
      m.gap(20);
      check_eq("burst_dropped", 0, n_req + n_pre + n_dqon);
      one_read(6'd8, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 6'h11);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      {fails, n_tests, cyc, t_req, t_dq, t_pre, t_off, t_end} = '0;
      {dqoe_q, dqsoe_q, dqs_q, cap_b32, cap_col} = '0;
      rst_i = 1'b1;
      cfg(6'd8, 1'b0, 1'b0, 1'b0, 1'b0);
      repeat (11) @(posedge clk_i);
      #1;
      rst_i = 1'b0;
      repeat (4) @(posedge clk_i);
      one_read(6'd8, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 6'h06);
      one_read(6'd5, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 6'h2e);
      gapless();
      refusals();
      mid_reset();
      act_spacing();
      tally_and_finish();
   end
   initial
   begin
      #2000000; // far beyond the few hundred command clocks of the run
      fails++;
      tally_and_finish();
   end
endmodule
bind ldr_read_core ldr_read_core_assertions u_ast (.clk_i(clk_i), .rst_i(rst_i), .toggle_preamble_i(toggle_preamble_i),
   .ext_postamble_i(ext_postamble_i), .rd_req_o(rd_req_o), .rd_col_o(rd_col_o), .dq_oe_o(dq_oe_o), .dqs_o(dqs_o),
   .dqs_oe_o(dqs_oe_o));
